// [verilog/arb_cpu_sync.sv]
// Functional notes
// - Reset puts gate machine idle, outputs off
// - Idle to enable: BAC request, line idle, PCI
// - Enable state drives local request onto backplane
// - Back to idle: PCI lost, or granted and line idle
// - Gate machine reacts without waiting arbitration edge
// - Never start requesting while another card requests
// - Offboard decode deglitched before the request controller
// - Offboard request set on address strobe trailing edge
// - Offboard request cleared when ready returns
// - Bus owned resynchronised to CPU clock before use
// - Offboard cycle locks arbiter until it completes
// - Split word transfers locked as one set
// - Odd address word pairs need no lock
// - CPU lock output prevents bus loss
// - Software bus hold bit acts as lock
// - Lock sources synchronised to CPU clock
// - Release request clocked, only when owned, unlocked
// - CPU waits until drive bus indication arrives
// - Write to CPU port raises interprocessor event, except for CPU number 0
// - Unlocked handover: release sync plus three edges
// - Drive bus indication readable as status
// - Higher priority requesters served first
// - Bus access controller steps on arbitration falling edge
// - Request state: PCO low, request, grant on PCI
`timescale 1ns/1ps
`default_nettype none
module arb_cpu_sync
   import arb_sync_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic arb_clk_in,
   input wire logic pci_in,
   input wire logic busrq_n_in,
   input wire logic busak_n_in,
   input wire logic offboard_cycle_decode,
   input wire logic addr_strobe,
   input wire logic cpu_ready,
   input wire logic cpu_lock,
   input wire logic split_xfer_active,
   input wire logic software_bus_hold_bit,
   input wire logic [CPU_NUM_W-1:0] cpu_number,
   input wire logic io_write,
   input wire logic [IO_ADDR_W-1:0] io_addr,
   output logic pco_out,
   output logic busrq_n_out,
   output logic busrq_n_oe,
   output logic busak_n_out,
   output logic busak_n_oe,
   output logic request_drive_enable,
   output logic bus_owned_indication,
   output logic drive_bus_indication,
   output logic lock_qualified_release_request,
   output logic cpu_wait,
   output logic ipi_pulse
);

   // Pin synchronisers: three stages, filtered on agreement
   logic [SYNC_W-1:0] s1_q;
   logic [SYNC_W-1:0] s2_q;
   logic [SYNC_W-1:0] s3_q;
   logic [SYNC_W-1:0] f_q;
   wire logic [SYNC_W-1:0] pins;
   wire logic [SYNC_W-1:0] agree;

   assign pins = {software_bus_hold_bit, split_xfer_active, cpu_lock, cpu_ready,
                  addr_strobe, offboard_cycle_decode, busak_n_in, busrq_n_in,
                  pci_in, arb_clk_in};
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s1_q <= SYNC_RESET;
         s2_q <= SYNC_RESET;
         s3_q <= SYNC_RESET;
         f_q <= SYNC_RESET;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q <= (agree & s3_q) | (~agree & f_q);
      end
   end

   wire logic pci_s;
   wire logic busrq_idle;
   wire logic busak_idle;
   wire logic lock_cpu_s;
   wire logic split_s;
   wire logic hold_s;

   assign pci_s = f_q[IX_PCI];
   assign busrq_idle = f_q[IX_BUSRQ_N];
   assign busak_idle = f_q[IX_BUSAK_N];
   assign lock_cpu_s = f_q[IX_CPU_LOCK];
   assign split_s = f_q[IX_SPLIT];
   assign hold_s = f_q[IX_HOLD];

   // Arbitration clock falling edge as an enable
   logic arb_prev_q;
   wire logic arb_fall;

   assign arb_fall = arb_prev_q & ~f_q[IX_ARB_CLK];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arb_prev_q <= 1'b0;
      end else begin
         arb_prev_q <= f_q[IX_ARB_CLK];
      end
   end

   // Offboard cycle deglitch
   offboard_if ob ();
   assign ob.decode = f_q[IX_DECODE];
   assign ob.strobe = f_q[IX_STROBE];
   assign ob.ready = f_q[IX_READY];

   offboard_deglitch u_deglitch (
      .clk_sys(clk_sys),
      .reset(reset),
      .ob(ob.filt)
   );

   wire logic offboard_req;
   assign offboard_req = ob.request;

   // State registers
   gate_e gate_q;
   gate_e gate_d;
   bac_e bac_q;
   bac_e bac_d;
   crq_e crq_q;
   crq_e crq_d;

   wire logic lock_any;
   wire logic other_req;
   wire logic crq_request;
   wire logic crq_release;
   wire logic bac_grant;

   // Lock covers sensed cycle, split sets, CPU lock and hold bit
   assign lock_any = offboard_req | ob.decode | split_s | lock_cpu_s | hold_s;
   // Odd address pairs rely on the CPU lock only
   assign other_req = ~busrq_idle & ~busrq_n_oe;
   assign crq_request = (crq_q == CRQ_REQUEST);
   assign crq_release = (crq_q == CRQ_RELEASE);
   assign bac_grant = (bac_q == BAC_GRANT);

   // Bus access controller, moves only on arbitration edge
   always_comb begin
      bac_d = bac_q;
      if (arb_fall) begin
         case (bac_q)
            BAC_IDLE: begin
               if (crq_request && busrq_idle) begin
                  bac_d = BAC_BUSRQ;
               end
            end
            BAC_BUSRQ: begin
               if (pci_s && busak_idle) begin
                  bac_d = BAC_GRANT;
               end
            end
            BAC_GRANT: begin
               if (crq_release) begin
                  bac_d = BAC_IDLE;
               end
            end
            default: bac_d = BAC_BUSRQ;
         endcase
      end
   end

   // CPU request controller: entry to request and release are immediate
   always_comb begin
      crq_d = crq_q;
      case (crq_q)
         CRQ_LOCAL: begin
            if (offboard_req) begin
               crq_d = CRQ_REQUEST;
            end
         end
         CRQ_REQUEST: begin
            if (arb_fall && bac_grant) begin
               crq_d = CRQ_OWNED;
            end
         end
         CRQ_OWNED: begin
            if (lock_qualified_release_request) begin
               crq_d = CRQ_RELEASE;
            end
         end
         CRQ_RELEASE: begin
            if (arb_fall && !bac_grant) begin
               crq_d = CRQ_LOCAL;
            end
         end
         default: crq_d = CRQ_REQUEST;
      endcase
   end

   // Request gate machine, follows inputs every system cycle
   always_comb begin
      gate_d = gate_q;
      case (gate_q)
         GATE_IDLE: begin
            if (bac_q == BAC_BUSRQ && busrq_idle && pci_s) begin
               gate_d = GATE_ENABLE;
            end
         end
         GATE_ENABLE: begin
            if (!pci_s || (bac_grant && busrq_idle)) begin
               gate_d = GATE_IDLE;
            end
         end
         default: gate_d = GATE_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gate_q <= GATE_IDLE;
         bac_q <= BAC_BUSRQ;
         crq_q <= CRQ_REQUEST;
      end else begin
         gate_q <= gate_d;
         bac_q <= bac_d;
         crq_q <= crq_d;
      end
   end

   // Backplane drive terms
   wire logic drive_en_d;
   wire logic busrq_drive_d;
   wire logic busak_drive_d;
   wire logic pco_d;

   assign drive_en_d = (gate_d == GATE_ENABLE);
   assign busrq_drive_d = drive_en_d && (bac_d == BAC_BUSRQ);
   assign busak_drive_d = (bac_d == BAC_GRANT) || (crq_d == CRQ_OWNED) || (crq_d == CRQ_RELEASE);
   assign pco_d = (bac_d == BAC_BUSRQ) ? 1'b0 : pci_s;

   // Bus owned resynchronised before ending waits
   logic owned_s1_q;
   wire logic owned_raw;
   wire logic release_d;
   wire logic wait_d;
   wire logic ipi_d;

   assign owned_raw = (crq_q == CRQ_OWNED);
   // Release only when owned, unlocked and someone else asks
   assign release_d = (crq_q == CRQ_OWNED) && !lock_any && other_req;
   assign wait_d = offboard_req && !drive_bus_indication;
   assign ipi_d = io_write && (cpu_number != 3'h0) && (io_addr == ipi_port(cpu_number));

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pco_out <= 1'b0;
         busrq_n_out <= 1'b1;
         busrq_n_oe <= 1'b0;
         busak_n_out <= 1'b1;
         busak_n_oe <= 1'b0;
         request_drive_enable <= 1'b0;
         bus_owned_indication <= 1'b0;
         owned_s1_q <= 1'b0;
         drive_bus_indication <= 1'b0;
         lock_qualified_release_request <= 1'b0;
         cpu_wait <= 1'b0;
         ipi_pulse <= 1'b0;
      end else begin
         pco_out <= pco_d;
         busrq_n_out <= ~busrq_drive_d;
         busrq_n_oe <= busrq_drive_d;
         busak_n_out <= ~busak_drive_d;
         busak_n_oe <= busak_drive_d;
         request_drive_enable <= drive_en_d;
         bus_owned_indication <= owned_raw;
         owned_s1_q <= owned_raw;
         drive_bus_indication <= owned_s1_q;
         lock_qualified_release_request <= release_d;
         cpu_wait <= wait_d;
         ipi_pulse <= ipi_d;
      end
   end

   // Checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_gate_reset_idle: assert property (
      $fell(reset) |-> gate_q == GATE_IDLE && !request_drive_enable && !busrq_n_oe)
      else $error("gate machine not idle after reset");

   a_gate_enter: assert property (
      gate_q == GATE_IDLE && bac_q == BAC_BUSRQ && busrq_idle && pci_s
      |=> gate_q == GATE_ENABLE ##0 request_drive_enable)
      else $error("gate machine missed enable condition");

   a_drive_needs_enable: assert property (
      busrq_n_oe |-> request_drive_enable && !busrq_n_out)
      else $error("request driven without drive enable");

   a_gate_leave_pci: assert property (
      gate_q == GATE_ENABLE && !pci_s |=> gate_q == GATE_IDLE ##1 !request_drive_enable)
      else $error("gate machine held after PCI loss");

   a_gate_no_edge_wait: assert property (
      gate_q == GATE_ENABLE && bac_grant && busrq_idle && !arb_fall |=> gate_q == GATE_IDLE)
      else $error("gate machine waited for arbitration edge");

   a_no_collide: assert property (
      $rose(request_drive_enable) |-> $past(busrq_idle))
      else $error("request enabled while backplane line busy");

   a_bac_on_edge: assert property (
      bac_q != $past(bac_q) |-> $past(arb_fall))
      else $error("bus access controller moved off arbitration edge");

   a_bac_pco_low: assert property (
      bac_q == BAC_BUSRQ ##1 bac_q == BAC_BUSRQ |-> !pco_out)
      else $error("PCO not lowered in request state");

   a_owned_resync: assert property (
      $rose(owned_raw) |-> !drive_bus_indication ##2 drive_bus_indication)
      else $error("drive bus indication not two-stage resynchronised");

   a_release_qual: assert property (
      lock_qualified_release_request |-> $past(owned_raw) && !$past(lock_any))
      else $error("release request while locked or not owned");

   a_hold_locks: assert property (
      hold_s |=> !lock_qualified_release_request)
      else $error("release request despite bus hold bit");

   a_cpu_waits: assert property (
      offboard_req && !drive_bus_indication |=> cpu_wait)
      else $error("CPU not held in wait states");

   a_wait_ends: assert property (
      drive_bus_indication |=> !cpu_wait)
      else $error("CPU wait held with bus driven");

   a_ipi_single: assert property (
      ipi_pulse ##1 ipi_pulse |-> $past(io_write) && $past(io_write, 2))
      else $error("interprocessor pulse stretched");

   a_ipi_cause: assert property (
      ipi_pulse |-> $past(io_write) && $past(io_addr[11:0]) == IPI_PORT_LOW)
      else $error("interprocessor pulse without port write");

endmodule
`default_nettype wire

// [shared/arb_sync_pkg.sv]
package arb_sync_pkg;

   // Pin synchroniser lanes
   localparam int SYNC_W = 10;
   localparam int IX_ARB_CLK = 0;
   localparam int IX_PCI = 1;
   localparam int IX_BUSRQ_N = 2;
   localparam int IX_BUSAK_N = 3;
   localparam int IX_DECODE = 4;
   localparam int IX_STROBE = 5;
   localparam int IX_READY = 6;
   localparam int IX_CPU_LOCK = 7;
   localparam int IX_SPLIT = 8;
   localparam int IX_HOLD = 9;
   // Idle levels: request and acknowledge lines high, bus hold on
   localparam logic [SYNC_W-1:0] SYNC_RESET = 10'h20C;

   // Interprocessor interrupt port map
   localparam int CPU_NUM_W = 3;
   localparam int IO_ADDR_W = 16;
   localparam logic [11:0] IPI_PORT_LOW = 12'h330;

   typedef enum logic [1:0] {
      GATE_IDLE = 2'h1,
      GATE_ENABLE = 2'h2
   } gate_e;

   typedef enum logic [2:0] {
      BAC_IDLE = 3'h1,
      BAC_BUSRQ = 3'h2,
      BAC_GRANT = 3'h4
   } bac_e;

   typedef enum logic [3:0] {
      CRQ_LOCAL = 4'h1,
      CRQ_REQUEST = 4'h2,
      CRQ_OWNED = 4'h4,
      CRQ_RELEASE = 4'h8
   } crq_e;

   // Port address that interrupts a given CPU number
   function automatic logic [IO_ADDR_W-1:0] ipi_port(input logic [CPU_NUM_W-1:0] num);
      ipi_port = {1'h0, num, IPI_PORT_LOW};
   endfunction

endpackage

// [shared/offboard_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface offboard_if;
   logic decode;
   logic strobe;
   logic ready;
   logic request;
   modport ctrl(output decode, output strobe, output ready, input request);
   modport filt(input decode, input strobe, input ready, output request);
endinterface
`default_nettype wire

// [verilog/offboard_deglitch.sv]
`timescale 1ns/1ps
`default_nettype none
module offboard_deglitch
   import arb_sync_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   offboard_if.filt ob
);

   logic strobe_prev_q;
   logic req_q;
   logic req_d;
   wire logic strobe_fall;
   wire logic set_req;

   assign strobe_fall = strobe_prev_q & ~ob.strobe;
   // Set on trailing strobe edge, set wins over clear
   assign set_req = strobe_fall & ob.decode;
   assign req_d = set_req | (req_q & ~ob.ready);
   assign ob.request = req_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         strobe_prev_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         strobe_prev_q <= ob.strobe;
         req_q <= req_d;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_set_on_strobe: assert property (
      set_req |=> ob.request)
      else $error("offboard request not set on strobe trailing edge");

   a_clear_on_ready: assert property (
      ob.request && ob.ready && !set_req |=> !ob.request)
      else $error("offboard request not cleared by ready");

   a_glitch_blocked: assert property (
      !ob.request && !set_req |=> !ob.request)
      else $error("offboard request set without strobe edge");

endmodule
`default_nettype wire

// [test/peer_arbiter_model.sv]
`timescale 1ns/1ps
`default_nettype none
module peer_arbiter_model (
   output logic arb_clk,
   input wire logic want,
   input wire logic our_rq_drive,
   input wire logic our_ak_drive,
   output logic busrq_line_n,
   output logic busak_line_n
);
   logic other_rq = 1'b0;
   logic other_ak = 1'b0;

   // Shared arbitration clock runs free
   initial begin
      arb_clk = 1'b1;
      #13;
      forever #40 arb_clk = ~arb_clk;
   end

   // Pulled-up wired lines
   assign busrq_line_n = ~(our_rq_drive | other_rq);
   assign busak_line_n = ~(our_ak_drive | other_ak);

   always @(negedge arb_clk) begin
      if (!want) begin
         other_rq <= 1'b0;
         other_ak <= 1'b0;
      end else if (!other_rq && !other_ak && !our_rq_drive) begin
         other_rq <= 1'b1;
      end else if (other_rq && !our_ak_drive) begin
         other_rq <= 1'b0;
         other_ak <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// [test/test_arb_cpu_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module test_arb_cpu_sync;
   import arb_sync_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic pci = 1'b0;
   logic want = 1'b0;
   logic decode = 1'b0;
   logic strobe = 1'b0;
   logic ready = 1'b0;
   logic cpu_lock = 1'b0;
   logic split = 1'b0;
   logic hold = 1'b1;
   logic [CPU_NUM_W-1:0] cpu_number = 3'h1;
   logic io_write = 1'b0;
   logic [IO_ADDR_W-1:0] io_addr = 16'h0000;
   wire arb_clk;
   wire rq_line_n;
   wire ak_line_n;
   logic pco, rq_out, rq_oe, ak_out, ak_oe, rde, owned, drive, rel, cpu_wait, ipi;
   int mismatches = 0;
   int tests_run = 0;
   logic ipi_q[$];
   logic own_q[$];
   logic drive_prev = 1'b0;
   logic saw_enable = 1'b0;
   logic saw_release = 1'b0;
   logic [IO_ADDR_W-1:0] addr;

   initial begin
      forever #4 clk_sys = ~clk_sys;
   end

   peer_arbiter_model i_peer (.arb_clk(arb_clk), .want(want),
      .our_rq_drive(rq_oe & ~rq_out), .our_ak_drive(ak_oe & ~ak_out),
      .busrq_line_n(rq_line_n), .busak_line_n(ak_line_n));

   arb_cpu_sync i_dut (.clk_sys(clk_sys), .reset(reset), .arb_clk_in(arb_clk),
      .pci_in(pci), .busrq_n_in(rq_line_n), .busak_n_in(ak_line_n),
      .offboard_cycle_decode(decode), .addr_strobe(strobe), .cpu_ready(ready),
      .cpu_lock(cpu_lock), .split_xfer_active(split), .software_bus_hold_bit(hold),
      .cpu_number(cpu_number), .io_write(io_write), .io_addr(io_addr),
      .pco_out(pco), .busrq_n_out(rq_out), .busrq_n_oe(rq_oe), .busak_n_out(ak_out),
      .busak_n_oe(ak_oe), .request_drive_enable(rde), .bus_owned_indication(owned),
      .drive_bus_indication(drive), .lock_qualified_release_request(rel),
      .cpu_wait(cpu_wait), .ipi_pulse(ipi));

   task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_ipi();
      if (ipi_q.size() == 0) begin
         check_val("ipi_pulse", 16'h0, {15'h0, ipi});
      end else begin
         check_val("ipi_pulse", {15'h0, ipi_q.pop_front()}, {15'h0, ipi});
      end
   endtask

   task automatic check_drive();
      if (own_q.size() == 0) begin
         check_val("drive_bus", {15'h0, drive_prev}, {15'h0, drive});
      end else begin
         check_val("drive_bus", {15'h0, own_q.pop_front()}, {15'h0, drive});
      end
   endtask

   task automatic wrap_up();
      $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic io_wr(input logic [IO_ADDR_W-1:0] a);
      io_write = 1'b1;
      io_addr = a;
      if (cpu_number != 3'h0 && a == {1'b0, cpu_number, IPI_PORT_LOW}) begin
         ipi_q.push_back(1'b1);
      end
      @(negedge clk_sys);
   endtask

   task automatic wait_drive(input logic lvl);
      int n;
      n = 0;
      while (drive !== lvl && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      check_val("drive_bus_wait", {15'h0, lvl}, {15'h0, drive});
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Result watchers
   always @(negedge clk_sys) begin
      if (ipi === 1'b1) begin
         check_ipi();
      end
      if (drive !== drive_prev) begin
         check_drive();
         if (drive === 1'b1) check_val("owned_before_drive", 16'h1, {15'h0, owned});
         drive_prev = drive;
      end
   end

   always @(posedge clk_sys) begin
      if (rde === 1'b1) saw_enable <= 1'b1;
      if (rel === 1'b1) saw_release <= 1'b1;
   end

   initial begin
      #200us;
      mismatches++;
      $display("BAD watchdog expected finish seen hang");
      wrap_up();
   end

   initial begin
      addr = 16'($urandom(45128));
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      check_val("reset_outputs", 16'h0003,
         {5'h0, pco, rq_oe, ak_oe, rde, owned, drive, rel, cpu_wait, ipi, rq_out, ak_out});
      reset = 1'b0;
      idle(2);
      for (int n = 0; n < 8; n++) begin
         cpu_number = n[2:0];
         idle(2);
         io_wr({1'b0, n[2:0], IPI_PORT_LOW});
         addr = 16'($urandom());
         io_wr(addr);
         io_wr({1'b0, n[2:0], IPI_PORT_LOW});
         io_write = 1'b0;
      end
      idle(40);
      check_val("no_enable_without_pci", 16'h0, {15'h0, rde});
      check_val("pco_request_low", 16'h0, {15'h0, pco});
      own_q.push_back(1'b1);
      pci = 1'b1;
      for (int n = 0; n < 200 && rde !== 1'b1 && drive !== 1'b1; n++) @(negedge clk_sys);
      pci = 1'b0;
      idle(12);
      check_val("enable_drops_on_pci", 16'h0, {15'h0, rde});
      pci = 1'b1;
      wait_drive(1'b1);
      check_val("enable_seen", 16'h1, {15'h0, saw_enable});
      idle(4);
      check_val("no_wait_owned", 16'h0, {15'h0, cpu_wait});
      saw_release = 1'b0;
      want = 1'b1;
      idle(80);
      check_val("hold_bit_lock", 16'h0, {15'h0, saw_release});
      hold = 1'b0;
      cpu_lock = 1'b1;
      idle(80);
      check_val("cpu_lock", 16'h0, {15'h0, saw_release});
      cpu_lock = 1'b0;
      split = 1'b1;
      idle(80);
      check_val("split_lock", 16'h0, {15'h0, saw_release});
      split = 1'b0;
      decode = 1'b1;
      idle(80);
      check_val("cycle_lock", 16'h0, {15'h0, saw_release});
      decode = 1'b0;
      own_q.push_back(1'b0);
      wait_drive(1'b0);
      for (int n = 0; n < 40 && ak_line_n !== 1'b0; n++) @(negedge clk_sys);
      check_val("handover_time", 16'h0, {15'h0, ak_line_n});
      check_val("release_seen", 16'h1, {15'h0, saw_release});
      idle(40);
      decode = 1'b1;
      strobe = 1'b1;
      idle(3);
      strobe = 1'b0;
      idle(20);
      check_val("wait_not_owned", 16'h1, {15'h0, cpu_wait});
      own_q.push_back(1'b1);
      want = 1'b0;
      wait_drive(1'b1);
      idle(4);
      check_val("wait_ends", 16'h0, {15'h0, cpu_wait});
      ready = 1'b1;
      decode = 1'b0;
      idle(6);
      ready = 1'b0;
      own_q.push_back(1'b0);
      want = 1'b1;
      wait_drive(1'b0);
      idle(40);
      decode = 1'b1;
      idle(1);
      decode = 1'b0;
      idle(20);
      check_val("glitch_ignored", 16'h0, {15'h0, cpu_wait});
      decode = 1'b1;
      idle(6);
      strobe = 1'b1;
      idle(1);
      strobe = 1'b0;
      idle(20);
      check_val("strobe_glitch_ignored", 16'h0, {15'h0, cpu_wait});
      decode = 1'b0;
      idle(6);
      check_val("queues_empty", 16'h0, 16'(ipi_q.size() + own_q.size()));
      wrap_up();
   end
endmodule
`default_nettype wire
